//--- rtl/qbport_pkg.sv
// Purpose: shared constants and carriers for the quasi-bidirectional port block
// Assumes: six 8-bit ports, index 0 is the open-drain bus port
// Notes: phase enables come from the cpu timing generator
package qbport_pkg;
  localparam int PortCount = 6;
  localparam int PortWidth = 8;
  localparam int BusPort = 0;
  localparam int AddrHighPort = 2;
  localparam logic [7:0] LatchResetValue = 8'hff;
  localparam logic [7:0] AllOnes = 8'hff;
  localparam logic [2:0] PortSelWidthMax = 3'h5;
  // boost length in oscillator periods
  localparam int BoostPeriods = 2;
  localparam logic [1:0] BoostCount = 2'(BoostPeriods);

  // cpu strobes toward the port block
  typedef struct packed {
    logic [PortCount-1:0] writeLatch;
    logic [PortCount-1:0] readLatch;
    logic [PortCount-1:0] readPin;
  } cpu_strobe_s;

  // per-pin drive enables toward the pads
  typedef struct packed {
    logic [PortWidth-1:0] strongPulldown;
    logic [PortWidth-1:0] weakPullup;
    logic [PortWidth-1:0] boostPullup;
    logic [PortWidth-1:0] keeperPullup;
  } drive_en_s;

  // pin drive state, one-hot
  typedef enum logic [3:0] {
    input_low_state = 4'h1,
    steady_high_state = 4'h2,
    boosted_high_state = 4'h4,
    drive_low_state = 4'h8
  } pin_state_e;
endpackage

//--- rtl/quasi_bidir_port_driver_ctrl.sv
// Purpose: latches, read paths and driver enables for six 8-bit I/O ports
// Assumes: one 10 MHz clock, phaseOneEn marks the P1 of each state,
//          stateOneEn marks state 1 of each machine cycle
// Notes: alternate functions and the analog input port are not covered
`timescale 1ns/1ps

module quasi_bidir_port_driver_ctrl #(
  parameter int Ports = qbport_pkg::PortCount,
  parameter int Width = qbport_pkg::PortWidth,
  parameter bit SecondVariant = 1'b1
) (
  input wire logic sysClk,
  input wire logic reset,
  input wire logic phaseOneEn,
  input wire logic stateOneEn,
  input wire qbport_pkg::cpu_strobe_s cpuStrobe,
  input wire logic [Width-1:0] writeData,
  output logic [Width-1:0] readData,
  input wire logic [Ports*Width-1:0] pinLevelAsync,
  input wire logic external_access_select,
  input wire logic wideAddress,
  input wire logic [Width-1:0] busLowByte,
  input wire logic [Width-1:0] busHighByte,
  input wire logic busLowDriveOnes,
  output logic [Ports*Width-1:0] strong_pulldown,
  output logic [Ports*Width-1:0] weak_pullup,
  output logic [Ports*Width-1:0] boost_pullup,
  output logic [Ports*Width-1:0] keeper_pullup
);

  logic [Width-1:0] latch_q [Ports];
  logic [Width-1:0] outBuf_q [Ports];
  logic [Width-1:0] prevBuf_q [Ports];
  logic [Width-1:0] boost_q [Ports];
  logic [1:0] boostCnt_q [Ports];
  logic [Ports*Width-1:0] pinMeta_q;
  logic [Ports*Width-1:0] pinSync_q;
  logic [Width-1:0] readData_d;
  logic [Ports*Width-1:0] drive_d;
  logic [Ports*Width-1:0] boostLive_d;
  logic [Ports*Width-1:0] pd_d;
  logic [Ports*Width-1:0] wk_d;
  logic [Ports*Width-1:0] bo_d;
  logic [Ports*Width-1:0] kp_d;
  logic busMode_q;

  // select one byte of a flat per-port vector
  function automatic logic [Width-1:0] portByte(input logic [Ports*Width-1:0] v,
                                                input int p);
    portByte = v[p*Width +: Width];
  endfunction

  // true for the open-drain port that carries the low bus byte
  function automatic logic isBusLow(input int p);
    isBusLow = (p == qbport_pkg::BusPort);
  endfunction

  // true while the high address byte owns port two
  function automatic logic isBusHigh(input int p,
                                     input logic bus,
                                     input logic wide);
    isBusHigh = (p == qbport_pkg::AddrHighPort) && bus && wide;
  endfunction

  // weak pullups after reset: every quasi port, never port zero
  function automatic logic [Ports*Width-1:0] weakResetPattern();
    weakResetPattern = '1;
    weakResetPattern[qbport_pkg::BusPort*Width +: Width] = '0;
  endfunction

  // two-flop synchroniser for pin levels
  always_ff @(posedge sysClk) begin
    pinMeta_q <= pinLevelAsync;
    pinSync_q <= pinMeta_q;
  end

  // external bus ownership registered on phase one
  always_ff @(posedge sysClk) begin
    if (reset) begin
      busMode_q <= 1'b0;
    end else if (phaseOneEn) begin
      busMode_q <= external_access_select;
    end
  end

  // port latches: cpu writes, bus mode fills port zero
  always_ff @(posedge sysClk) begin
    for (int p = 0; p < Ports; p++) begin
      if (reset) begin
        latch_q[p] <= qbport_pkg::LatchResetValue;
      end else if (busMode_q && p == qbport_pkg::BusPort) begin
        latch_q[p] <= qbport_pkg::AllOnes;
      end else if (cpuStrobe.writeLatch[p]) begin
        latch_q[p] <= writeData;
      end
    end
  end

  // output buffers sample the latch only in phase one
  always_ff @(posedge sysClk) begin
    for (int p = 0; p < Ports; p++) begin
      if (reset) begin
        outBuf_q[p] <= qbport_pkg::LatchResetValue;
        prevBuf_q[p] <= qbport_pkg::LatchResetValue;
      end else if (phaseOneEn) begin
        prevBuf_q[p] <= outBuf_q[p];
        outBuf_q[p] <= latch_q[p];
      end
    end
  end

  // boost timing: zero-to-one edge seen by the buffer
  always_ff @(posedge sysClk) begin
    for (int p = 0; p < Ports; p++) begin
      if (reset) begin
        boost_q[p] <= '0;
        boostCnt_q[p] <= '0;
      end else if (phaseOneEn && (latch_q[p] & ~outBuf_q[p]) != '0) begin
        boost_q[p] <= latch_q[p] & ~outBuf_q[p];
        boostCnt_q[p] <= qbport_pkg::BoostCount;
      end else if (boostCnt_q[p] != '0) begin
        boostCnt_q[p] <= boostCnt_q[p] - 2'h1;
        if (boostCnt_q[p] == 2'h1) begin
          boost_q[p] <= '0;
        end
      end
    end
  end

  // level driven toward each pad: buffered latch or bus byte
  always_comb begin
    drive_d = '0;
    for (int p = 0; p < Ports; p++) begin
      if (isBusLow(p) && busMode_q) begin
        drive_d[p*Width +: Width] = busLowByte;
      end else if (isBusHigh(p, busMode_q, wideAddress)) begin
        drive_d[p*Width +: Width] = busHighByte;
      end else begin
        drive_d[p*Width +: Width] = outBuf_q[p];
      end
    end
  end

  // bits still inside their two-period boost window
  always_comb begin
    boostLive_d = '0;
    for (int p = 0; p < Ports; p++) begin
      if (boostCnt_q[p] != '0) begin
        boostLive_d[p*Width +: Width] = boost_q[p];
      end
    end
  end

  // pulldown wherever a zero is driven, port zero included
  always_comb begin
    pd_d = ~drive_d;
  end

  // boost: bus ones on port zero, wide address on two, else edge window
  always_comb begin
    bo_d = '0;
    for (int p = 0; p < Ports; p++) begin
      if (isBusLow(p)) begin
        if (busMode_q && busLowDriveOnes) begin
          bo_d[p*Width +: Width] = drive_d[p*Width +: Width];
        end
      end else if (isBusHigh(p, busMode_q, wideAddress)) begin
        bo_d[p*Width +: Width] = drive_d[p*Width +: Width];
      end else begin
        bo_d[p*Width +: Width] = boostLive_d[p*Width +: Width]
                                 & drive_d[p*Width +: Width];
      end
    end
  end

  // weak pullup: never on port zero nor on a wide-address port two
  always_comb begin
    wk_d = '0;
    for (int p = 0; p < Ports; p++) begin
      if (!isBusLow(p) && !isBusHigh(p, busMode_q, wideAddress)) begin
        if (SecondVariant) begin
          wk_d[p*Width +: Width] = drive_d[p*Width +: Width];
        end else begin
          wk_d[p*Width +: Width] = '1;
        end
      end
    end
  end

  // keeper: buffered latch one and synchronised pin seen high
  always_comb begin
    kp_d = '0;
    for (int p = 0; p < Ports; p++) begin
      if (SecondVariant && !isBusLow(p) && !isBusHigh(p, busMode_q, wideAddress)) begin
        kp_d[p*Width +: Width] = drive_d[p*Width +: Width]
                                 & portByte(pinSync_q, p);
      end
    end
  end

  // registered pulldown enables
  always_ff @(posedge sysClk) begin
    if (reset) begin
      strong_pulldown <= '0;
    end else begin
      strong_pulldown <= pd_d;
    end
  end

  // registered weak pullups, port zero kept off in reset too
  always_ff @(posedge sysClk) begin
    if (reset) begin
      weak_pullup <= weakResetPattern();
    end else begin
      weak_pullup <= wk_d;
    end
  end

  // registered boost enables
  always_ff @(posedge sysClk) begin
    if (reset) begin
      boost_pullup <= '0;
    end else begin
      boost_pullup <= bo_d;
    end
  end

  // registered keeper enables, off through reset
  always_ff @(posedge sysClk) begin
    if (reset) begin
      keeper_pullup <= '0;
    end else begin
      keeper_pullup <= kp_d;
    end
  end

  // read mux: highest strobed port wins, latch strobe over pin strobe within a port
  always_comb begin
    readData_d = '0;
    for (int p = 0; p < Ports; p++) begin
      if (cpuStrobe.readLatch[p]) begin
        readData_d = latch_q[p];
      end else if (cpuStrobe.readPin[p]) begin
        readData_d = portByte(pinSync_q, p);
      end
    end
  end

  // registered read data
  always_ff @(posedge sysClk) begin
    if (reset) begin
      readData <= '0;
    end else begin
      readData <= readData_d;
    end
  end
endmodule

//--- verification/qbport_sva.sv
// Purpose: port-level checks for the port driver block
// Assumes: second variant, port 1 bit 0 is the boost probe
// Notes: pin level passes two flops before keeper logic
`timescale 1ns/1ps
module qbport_sva (
  input wire logic sysClk,
  input wire logic reset,
  input wire qbport_pkg::cpu_strobe_s cpuStrobe,
  input wire logic [47:0] pinLevelAsync,
  input wire logic busLowDriveOnes,
  input wire logic [7:0] readData,
  input wire logic [47:0] strong_pulldown,
  input wire logic [47:0] weak_pullup,
  input wire logic [47:0] boost_pullup,
  input wire logic [47:0] keeper_pullup
);
  default clocking @(posedge sysClk); endclocking
  default disable iff (reset);
  // drive enables against latch and pin
  weak_vs_low_a:
    assert property ({weak_pullup[47:24], weak_pullup[15:8]}
      == ~{strong_pulldown[47:24], strong_pulldown[15:8]}) else $error("weak/low clash");
  port_two_excl_a:
    assert property ((weak_pullup[23:16] & strong_pulldown[23:16]) == 8'h00)
      else $error("port two weak and low");
  boost_len_a:
    assert property ($rose(boost_pullup[8]) |=> boost_pullup[8] ##1 !boost_pullup[8])
      else $error("boost length wrong");
  boost_excl_a:
    assert property ((boost_pullup[47:8] & strong_pulldown[47:8]) == '0) else $error("boost+low");
  keeper_pin_a:
    assert property (!pinLevelAsync[8] [*4] |-> !keeper_pullup[8]) else $error("keeper on low");
  keeper_weak_a:
    assert property ((keeper_pullup & ~weak_pullup) == '0) else $error("keeper alone");
  reset_vals_a:
    assert property ($past(reset) |-> weak_pullup[47:8] == '1 && boost_pullup == '0
      && keeper_pullup == '0) else $error("reset enables wrong");
  read_idle_a:
    assert property (!$past(|cpuStrobe.readLatch || |cpuStrobe.readPin) |-> readData == 8'h00)
      else $error("read data without strobe");
  port_zero_a:
    assert property (weak_pullup[7:0] == 8'h00 && keeper_pullup[7:0] == 8'h00)
      else $error("port zero pullup");
  bus_pullup_a:
    assert property (!busLowDriveOnes [*3] |-> boost_pullup[7:0] == 8'h00)
      else $error("port zero bus pullup");
endmodule

bind quasi_bidir_port_driver_ctrl qbport_sva i_sva (.sysClk, .reset, .cpuStrobe,
  .pinLevelAsync, .busLowDriveOnes, .readData, .strong_pulldown, .weak_pullup,
  .boost_pullup, .keeper_pullup);

//--- verification/port_load.sv
// Purpose: pin loads seen by the port driver block
// Assumes: port 0 lines carry external pullup resistors
// Notes: an external source may sink any line
`timescale 1ns/1ps
module port_load (
  input wire logic [47:0] pd,
  input wire logic [47:0] extLow,
  output logic [47:0] pin
);
  // pulldown or external sink wins, otherwise pulled high
  assign pin = ~(pd | extLow);
endmodule

//--- verification/quasi_bidir_port_driver_ctrl_tb.sv
// Purpose: self-checking bench for the port driver block
// Assumes: phase one every second cycle
// Notes: enables read several cycles after a write
`timescale 1ns/1ps
module quasi_bidir_port_driver_ctrl_tb;
  logic sysClk = 1'b0, reset = 1'b1, phaseOneEn = 1'b0;
  logic extSel = 1'b0, wideAddr = 1'b0, lowOnes = 1'b0;
  qbport_pkg::cpu_strobe_s cpuStrobe = '0;
  logic [7:0] writeData = 8'h00, busLowByte = 8'h00, busHighByte = 8'h00, readData, rv;
  logic [47:0] extLow = '0, pin, pd, wk, bs, kp;
  int n_mismatch = 0, n_compared = 0, cyc = 0, bCnt = 0, b0, p;
  // port, data, expected pulldown byte
  logic [19:0] rows [8] = '{20'h100ff, 20'h1a55a, 20'h2ff00, 20'h33cc3,
    20'h400ff, 20'h5c33c, 20'h05aa5, 20'h2817e};
  quasi_bidir_port_driver_ctrl i_dut (.sysClk, .reset, .phaseOneEn,
    .stateOneEn(phaseOneEn & cyc[3]), .cpuStrobe, .writeData, .readData,
    .pinLevelAsync(pin), .external_access_select(extSel), .wideAddress(wideAddr),
    .busLowByte, .busHighByte, .busLowDriveOnes(lowOnes), .strong_pulldown(pd),
    .weak_pullup(wk), .boost_pullup(bs), .keeper_pullup(kp));
  port_load i_load (.pd, .extLow, .pin);
  initial begin
    forever #50 sysClk = ~sysClk;
  end
  // phase pulses and hang limit
  always @(posedge sysClk) begin
    cyc <= cyc + 1;
    phaseOneEn <= ~phaseOneEn;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // boost cycles on port 1 bit 0
  always @(negedge sysClk) bCnt <= bCnt + bs[8];
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input int pt, input logic [7:0] d);
    @(posedge sysClk);
    cpuStrobe.writeLatch <= 6'h01 << pt;
    writeData <= d;
    @(posedge sysClk);
    cpuStrobe.writeLatch <= '0;
    repeat (6) @(posedge sysClk);
  endtask
  task automatic rd(input int pt, input bit fromPin);
    @(posedge sysClk);
    if (fromPin) cpuStrobe.readPin <= 6'h01 << pt;
    else cpuStrobe.readLatch <= 6'h01 << pt;
    @(posedge sysClk);
    cpuStrobe <= '0;
    @(negedge sysClk);
    rv = readData;
  endtask
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sysClk);
    reset <= 1'b0;
    rd(5, 0);
    chk("reset latch", 8'hff, rv);
    chk("reset low", 8'h00, pd[15:8]);
    $display("reset test done");
    foreach (rows[i]) begin
      p = rows[i][19:16];
      wr(p, rows[i][15:8]);
      rd(p, 0);
      chk("latch", rows[i][15:8], rv);
      rd(p, 1);
      chk("pin", rows[i][15:8], rv);
      chk("low", rows[i][7:0], pd[p*8+:8]);
      chk("weak", (p == 0) ? 8'h00 : rows[i][15:8], wk[p*8+:8]);
    end
    $display("row test done");
    wr(1, 8'h00);
    b0 = bCnt;
    wr(1, 8'h01);
    chk("boost", 8'h02, 8'(bCnt - b0));
    b0 = bCnt;
    wr(1, 8'h01);
    chk("reboost", 8'h00, 8'(bCnt - b0));
    chk("keeper on", 8'h01, {7'h0, kp[8]});
    @(posedge sysClk);
    extLow[8] <= 1'b1;
    repeat (6) @(posedge sysClk);
    rd(1, 1);
    chk("pin low", 8'h00, rv);
    chk("keeper off", 8'h00, {7'h0, kp[8]});
    $display("boost test done");
    @(posedge sysClk);
    extLow[8] <= 1'b0;
    extSel <= 1'b1;
    wideAddr <= 1'b1;
    busHighByte <= 8'h96;
    busLowByte <= 8'h5a;
    lowOnes <= 1'b1;
    repeat (6) @(posedge sysClk);
    rd(0, 0);
    chk("bus p0", 8'hff, rv);
    rd(2, 0);
    chk("bus p2", 8'h81, rv);
    chk("bus boost", 8'h96, bs[23:16]);
    chk("bus p0 ones", 8'h5a, bs[7:0]);
    chk("bus p0 low", 8'ha5, pd[7:0]);
    @(posedge sysClk);
    extSel <= 1'b0;
    wideAddr <= 1'b0;
    lowOnes <= 1'b0;
    $display("bus test done");
    end_sim();
  end
endmodule
